// file: src/tpa_consts.svh
`ifndef TPA_CONSTS_SVH
`define TPA_CONSTS_SVH

// Register indices; byte address is four times the index
`define TPA_IDX_CMP_DATA   8'h03
`define TPA_IDX_COUNT      8'h04
`define TPA_IDX_ACC_CTL    8'h20
`define TPA_IDX_PRESCALE   8'h21
`define TPA_IDX_CMP_MASK   8'h22
`define TPA_IDX_SYS_CTL    8'h23
`define TPA_IDX_IO_SEL     8'h24
`define TPA_IDX_PIN_DISC   8'h25
`define TPA_IDX_TOGGLE     8'h26
`define TPA_IDX_CH7_CMP    8'h27
`define TPA_IDX_ACC_COUNT  8'h28
`define TPA_IDX_ACC_FLAGS  8'h29
`define TPA_IDX_PORT       8'h2A

// Accumulator control fields
`define TPA_ACC_EN_BIT     6
`define TPA_ACC_MODE_BIT   5
`define TPA_ACC_EDGE_BIT   4
`define TPA_ACC_OVI_BIT    1
`define TPA_ACC_INI_BIT    0
`define TPA_ACC_CTL_MASK   8'h7F

// System control and toggle fields
`define TPA_SYS_RUN_BIT    7
`define TPA_SYS_PREC_BIT   3
`define TPA_TOGGLE_BIT     7

// Flag register fields
`define TPA_FLAG_OVF_BIT   1
`define TPA_FLAG_IN_BIT    0

// Reset values
`define TPA_RST_BYTE       8'h00
`define TPA_RST_WORD       16'h0000

// Gated-mode clock divider width: bus clock / 64
`define TPA_GATE_DIV_W     6

`endif

// file: src/tpa_pkg.sv
package tpa_pkg;
  typedef logic [7:0]  tpa_byte_t;
  typedef logic [15:0] tpa_word_t;
  typedef enum logic {TPA_EVENT_COUNT, TPA_GATED_TIME} tpa_mode_e;
endpackage

// file: src/tpa_prescaler.sv
`timescale 1ns/10ps
`include "tpa_consts.svh"
module tpa_prescaler
  import tpa_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire logic      enable,
  input  wire logic      precision_timer_enable,
  input  wire tpa_byte_t precision_divider_select,
  input  wire logic [2:0] std_select,
  output logic           tick
);
  tpa_byte_t cnt;
  tpa_byte_t active;
  tpa_byte_t target;

  // Terminal count: select in precision mode, else a power of two minus one
  always_comb begin
    if (precision_timer_enable) begin
      target = precision_divider_select;
    end else begin
      target = tpa_byte_t'((9'h001 << std_select) - 9'h001);
    end
  end

  // Divider stage; idle at zero while the timer is off
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= `TPA_RST_BYTE;
    end else if (!enable || cnt == active) begin
      cnt <= `TPA_RST_BYTE;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  // New factor only taken where the stage returns to zero, no runt periods
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active <= `TPA_RST_BYTE;
    end else if (!enable || cnt == active) begin
      active <= target;
    end
  end

  assign tick = enable && (cnt == active);
endmodule // tpa_prescaler

// file: src/tpa_accum.sv
`timescale 1ns/10ps
`include "tpa_consts.svh"
module tpa_accum
  import tpa_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire logic      pin,
  input  wire logic      accum_enable,
  input  wire tpa_mode_e mode,
  input  wire logic      accum_edge_control,
  input  wire logic      load,
  input  wire tpa_word_t load_value,
  input  wire logic      clr_ovf,
  input  wire logic      clr_in,
  output tpa_word_t      count,
  output logic           accum_overflow_flag,
  output logic           accum_input_flag
);
  logic [2:0] sync;
  logic       level;
  logic [`TPA_GATE_DIV_W-1:0] div;
  logic       agree;
  logic       rise;
  logic       fall;
  logic       inc;
  logic       in_set;
  logic       ovf_set;

  // Pin synchroniser; first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync <= 3'h0;
    end else begin
      sync <= {sync[1:0], pin};
    end
  end

  // Filtered level changes only when stages two and three agree
  assign agree = (sync[1] == sync[2]);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level <= 1'b0;
    end else if (agree) begin
      level <= sync[2];
    end
  end
  assign rise = agree && sync[2] && !level;
  assign fall = agree && !sync[2] && level;

  // Bus clock / 64 divider, runs only while enabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div <= '0;
    end else if (accum_enable) begin
      div <= div + `TPA_GATE_DIV_W'(1);
    end else begin
      div <= '0;
    end
  end

  // Count source selection; independent of the main timer enable
  always_comb begin
    inc    = 1'b0;
    in_set = 1'b0;
    if (accum_enable) begin
      if (mode == TPA_EVENT_COUNT) begin
        inc    = accum_edge_control ? rise : fall;
        in_set = inc;
      end else begin
        inc    = (&div) && (level == !accum_edge_control);
        in_set = accum_edge_control ? rise : fall;
      end
    end
  end
  assign ovf_set = inc && (count == 16'hFFFF);

  // Software load wins over an increment in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= `TPA_RST_WORD;
    end else if (load) begin
      count <= load_value;
    end else if (inc) begin
      count <= count + 16'h0001;
    end
  end

  // Sticky flags; a set in the clearing cycle survives
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      accum_overflow_flag <= 1'b0;
      accum_input_flag    <= 1'b0;
    end else begin
      accum_overflow_flag <= ovf_set | (accum_overflow_flag & ~clr_ovf);
      accum_input_flag    <= in_set | (accum_input_flag & ~clr_in);
    end
  end
endmodule // tpa_accum

// file: src/tpa_top.sv
// Function
// - Precision prescaler divides by select plus one
// - New factor applies when all stages zero
// - Channel 7 event overrides channel 6-0 compares
// - Masked port bits take channel 7 data
// - Data reaches pin only if compare, connected
// - Accumulator runs on own enable only
// - Accumulator input is the channel 7 pin
// - Mode bit selects event or gated
// - Event mode counts falling or rising edges
// - Gated mode counts clock/64, trailing edge flags
// - Overflow flag with enable requests interrupt
// - Input flag with enable requests interrupt
// - Channel 7 data register always read/write
`timescale 1ns/10ps
`include "tpa_consts.svh"
module tpa_top
  import tpa_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic [31:0]      PRDATA,
  output logic             PSLVERR,
  input  wire logic        CH7_PIN,
  input  wire logic [6:0]  LOW_CMP_EVT,
  input  wire logic [6:0]  LOW_CMP_LVL,
  output logic [7:0]       TIMER_PORT,
  output logic             ACCUM_OVF_IRQ,
  output logic             ACCUM_IN_IRQ
);
  tpa_byte_t  ch7_compare_data;
  tpa_byte_t  ch7_compare_mask;
  tpa_byte_t  precision_prescale_select;
  tpa_byte_t  accumulator_control;
  tpa_byte_t  timer_system_control_one;
  tpa_byte_t  channel_io_select;
  tpa_byte_t  compare_pin_disconnect;
  tpa_byte_t  toggle_reg;
  tpa_word_t  free_running_count;
  tpa_word_t  ch7_compare_value;
  tpa_word_t  acc_count;
  logic       accum_overflow_flag;
  logic       accum_input_flag;
  logic       tick;
  logic       overflow;
  logic       ch7_event;
  logic       setup;
  logic       wr_en;
  logic [7:0] idx;
  logic       hit;
  logic [31:0] rd_data;
  logic       main_timer_enable;
  logic       precision_timer_enable;
  logic       toggle_on_overflow;
  logic       accum_enable;

  // Index match of the word address against a register index
  function automatic logic tpa_sel(input logic [7:0] a, input logic [7:0] i);
    return a == i;
  endfunction

  // Port bit may be driven by compare logic only when set up for it
  function automatic logic tpa_out_ok(input logic ios, input logic disc);
    return ios && !disc;
  endfunction

  assign main_timer_enable      = timer_system_control_one[`TPA_SYS_RUN_BIT];
  assign precision_timer_enable = timer_system_control_one[`TPA_SYS_PREC_BIT];
  assign toggle_on_overflow     = toggle_reg[`TPA_TOGGLE_BIT];
  assign accum_enable           = accumulator_control[`TPA_ACC_EN_BIT];

  // APB decode; word index is the byte address divided by four
  assign idx   = PADDR[9:2];
  assign setup = PSEL && !PENABLE;
  assign wr_en = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;

  // Zero-wait slave: ready and read data are registered at setup
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else if (setup) begin
      PREADY  <= 1'b1;
      PSLVERR <= !hit || (PADDR[11:10] != 2'b00);
    end else begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  // Read data captured at setup; unmapped reads return zero, writes hold it, idle clears it
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (setup && !PWRITE) begin
      PRDATA <= (PADDR[11:10] == 2'b00) ? rd_data : 32'h0000_0000;
    end else if (!PSEL) begin
      PRDATA <= 32'h0000_0000;
    end
  end

  // Read multiplexer; narrow registers sit in the low bits
  always_comb begin
    rd_data = 32'h0000_0000;
    hit     = 1'b1;
    unique case (1'b1)
      tpa_sel(idx, `TPA_IDX_CMP_DATA):  rd_data[7:0] = ch7_compare_data;
      tpa_sel(idx, `TPA_IDX_COUNT):     rd_data[15:0] = free_running_count;
      tpa_sel(idx, `TPA_IDX_ACC_CTL):   rd_data[7:0] = accumulator_control;
      tpa_sel(idx, `TPA_IDX_PRESCALE):
        rd_data[7:0] = precision_prescale_select;
      tpa_sel(idx, `TPA_IDX_CMP_MASK):  rd_data[7:0] = ch7_compare_mask;
      tpa_sel(idx, `TPA_IDX_SYS_CTL):
        rd_data[7:0] = timer_system_control_one;
      tpa_sel(idx, `TPA_IDX_IO_SEL):    rd_data[7:0] = channel_io_select;
      tpa_sel(idx, `TPA_IDX_PIN_DISC):
        rd_data[7:0] = compare_pin_disconnect;
      tpa_sel(idx, `TPA_IDX_TOGGLE):    rd_data[7:0] = toggle_reg;
      tpa_sel(idx, `TPA_IDX_CH7_CMP):   rd_data[15:0] = ch7_compare_value;
      tpa_sel(idx, `TPA_IDX_ACC_COUNT): rd_data[15:0] = acc_count;
      tpa_sel(idx, `TPA_IDX_ACC_FLAGS): begin
        rd_data[`TPA_FLAG_OVF_BIT] = accum_overflow_flag;
        rd_data[`TPA_FLAG_IN_BIT]  = accum_input_flag;
      end
      tpa_sel(idx, `TPA_IDX_PORT):      rd_data[7:0] = TIMER_PORT;
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // Byte-wide configuration registers
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ch7_compare_data          <= `TPA_RST_BYTE;
      ch7_compare_mask          <= `TPA_RST_BYTE;
      precision_prescale_select <= `TPA_RST_BYTE;
      timer_system_control_one  <= `TPA_RST_BYTE;
      channel_io_select         <= `TPA_RST_BYTE;
      compare_pin_disconnect    <= `TPA_RST_BYTE;
      toggle_reg                <= `TPA_RST_BYTE;
    end else if (wr_en) begin
      if (tpa_sel(idx, `TPA_IDX_CMP_DATA)) begin
        ch7_compare_data <= PWDATA[7:0];
      end
      if (tpa_sel(idx, `TPA_IDX_CMP_MASK)) begin
        ch7_compare_mask <= PWDATA[7:0];
      end
      if (tpa_sel(idx, `TPA_IDX_PRESCALE)) begin
        precision_prescale_select <= PWDATA[7:0];
      end
      if (tpa_sel(idx, `TPA_IDX_SYS_CTL)) begin
        timer_system_control_one <= PWDATA[7:0];
      end
      if (tpa_sel(idx, `TPA_IDX_IO_SEL)) begin
        channel_io_select <= PWDATA[7:0];
      end
      if (tpa_sel(idx, `TPA_IDX_PIN_DISC)) begin
        compare_pin_disconnect <= PWDATA[7:0];
      end
      if (tpa_sel(idx, `TPA_IDX_TOGGLE)) begin
        toggle_reg <= PWDATA[7:0] & 8'h80; // Only the channel 7 bit exists
      end
    end
  end

  // Accumulator control; bit 7 is reserved and reads zero
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      accumulator_control <= `TPA_RST_BYTE;
    end else if (wr_en && tpa_sel(idx, `TPA_IDX_ACC_CTL)) begin
      accumulator_control <= PWDATA[7:0] & `TPA_ACC_CTL_MASK;
    end
  end

  // Channel 7 compare value
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ch7_compare_value <= `TPA_RST_WORD;
    end else if (wr_en && tpa_sel(idx, `TPA_IDX_CH7_CMP)) begin
      ch7_compare_value <= PWDATA[15:0];
    end
  end

  // Main timer prescaler
  tpa_prescaler u_prescaler (
    .clk                      (SYS_CLK),
    .rst                      (RST),
    .enable                   (main_timer_enable),
    .precision_timer_enable   (precision_timer_enable),
    .precision_divider_select (precision_prescale_select),
    .std_select               (timer_system_control_one[2:0]),
    .tick                     (tick)
  );

  // Free-running counter; a software write wins over the tick
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      free_running_count <= `TPA_RST_WORD;
    end else if (wr_en && tpa_sel(idx, `TPA_IDX_COUNT)) begin
      free_running_count <= PWDATA[15:0];
    end else if (tick) begin
      free_running_count <= free_running_count + 16'h0001;
    end
  end

  // Channel 7 event: overflow with toggle enabled, or compare match
  assign overflow  = tick && (free_running_count == 16'hFFFF);
  assign ch7_event = (overflow && toggle_on_overflow) ||
                     (tick && (free_running_count == ch7_compare_value));

  // Timer port; masked bits follow channel 7, others the low channels
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      TIMER_PORT <= `TPA_RST_BYTE;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (ch7_event && ch7_compare_mask[i]) begin
          if (tpa_out_ok(channel_io_select[i], compare_pin_disconnect[i]))
          begin
            TIMER_PORT[i] <= ch7_compare_data[i];
          end
        end else if (i < 7) begin
          if (LOW_CMP_EVT[i[2:0]] &&
              tpa_out_ok(channel_io_select[i], compare_pin_disconnect[i]))
          begin
            TIMER_PORT[i] <= LOW_CMP_LVL[i[2:0]];
          end
        end
      end
    end
  end

  // Pulse accumulator on the shared channel 7 pin
  tpa_accum u_accum (
    .clk                 (SYS_CLK),
    .rst                 (RST),
    .pin                 (CH7_PIN),
    .accum_enable        (accum_enable),
    .mode                (tpa_mode_e'(accumulator_control[`TPA_ACC_MODE_BIT])),
    .accum_edge_control  (accumulator_control[`TPA_ACC_EDGE_BIT]),
    .load                (wr_en && tpa_sel(idx, `TPA_IDX_ACC_COUNT)),
    .load_value          (PWDATA[15:0]),
    .clr_ovf             (wr_en && tpa_sel(idx, `TPA_IDX_ACC_FLAGS) &&
                          PWDATA[`TPA_FLAG_OVF_BIT]),
    .clr_in              (wr_en && tpa_sel(idx, `TPA_IDX_ACC_FLAGS) &&
                          PWDATA[`TPA_FLAG_IN_BIT]),
    .count               (acc_count),
    .accum_overflow_flag (accum_overflow_flag),
    .accum_input_flag    (accum_input_flag)
  );

  // Interrupt requests, registered so the outputs come from flops
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ACCUM_OVF_IRQ <= 1'b0;
      ACCUM_IN_IRQ  <= 1'b0;
    end else begin
      ACCUM_OVF_IRQ <= accum_overflow_flag &&
                       accumulator_control[`TPA_ACC_OVI_BIT];
      ACCUM_IN_IRQ  <= accum_input_flag &&
                       accumulator_control[`TPA_ACC_INI_BIT];
    end
  end
endmodule // tpa_top

// file: testbench/tpa_pulse_src.sv
`timescale 1ns/10ps
module tpa_pulse_src (
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic       idle,
  input  wire logic [9:0] width,
  output logic            pin,
  output logic            busy
);
  logic [10:0] cnt = 11'h000;
  // Active half first, then an equal quiet gap before busy drops
  always @(posedge clk) begin
    if (start) begin
      cnt <= {width, 1'b0};
    end else if (cnt != 11'h000) begin
      cnt <= cnt - 11'h001;
    end
  end
  assign busy = cnt != 11'h000;
  // Pin is always driven: idle level outside the active half
  assign pin = idle ^ (cnt > {1'b0, width});
endmodule // tpa_pulse_src

// file: testbench/tpa_top_props.sv
`timescale 1ns/10ps
`include "tpa_consts.svh"
module tpa_top_props
  import tpa_pkg::*;
(
  input wire logic        SYS_CLK,
  input wire logic        RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic [31:0] PRDATA,
  input wire logic        PSLVERR,
  input wire logic        CH7_PIN,
  input wire logic [6:0]  LOW_CMP_EVT,
  input wire logic [6:0]  LOW_CMP_LVL,
  input wire logic [7:0]  TIMER_PORT,
  input wire logic        ACCUM_OVF_IRQ,
  input wire logic        ACCUM_IN_IRQ
);
  logic [7:0] dat_sh, ctl_sh, msk_sh, ios_sh, dis_sh;
  logic       wr_ok;
  // Only a completed, accepted access may change a shadow
  assign wr_ok = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
  // Shadows of the control bytes software has written
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      dat_sh <= 8'h00;
      ctl_sh <= 8'h00;
      msk_sh <= 8'h00;
      ios_sh <= 8'h00;
      dis_sh <= 8'h00;
    end else if (wr_ok) begin
      if (PADDR[9:2] == `TPA_IDX_CMP_DATA) dat_sh <= PWDATA[7:0];
      if (PADDR[9:2] == `TPA_IDX_ACC_CTL) ctl_sh <= PWDATA[7:0];
      if (PADDR[9:2] == `TPA_IDX_CMP_MASK) msk_sh <= PWDATA[7:0];
      if (PADDR[9:2] == `TPA_IDX_IO_SEL) ios_sh <= PWDATA[7:0];
      if (PADDR[9:2] == `TPA_IDX_PIN_DISC) dis_sh <= PWDATA[7:0];
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_read_data;
    s_setup ##0 (!PWRITE && PADDR == 12'h00C);
  endsequence
  chk_ready_access: assert property (s_setup |=> PREADY ##1 !PREADY)
    else $error("ready not single cycle after setup");
  chk_idle_quiet: assert property (!PSEL |=> !PREADY && !PSLVERR)
    else $error("ready or error without a transfer");
  chk_err_upper: assert property (s_setup ##0 (PADDR[11:10] != 2'b00)
    |=> PSLVERR && PRDATA == 32'h0000_0000)
    else $error("upper address bits not refused");
  chk_data_readback: assert property (
    s_read_data |=> PRDATA == {24'h00_0000, dat_sh})
    else $error("compare data readback wrong");
  chk_ovf_irq_off: assert property (
    !ctl_sh[1] && !$past(ctl_sh[1]) |-> !ACCUM_OVF_IRQ)
    else $error("overflow request while disabled");
  chk_in_irq_off: assert property (
    !ctl_sh[0] && !$past(ctl_sh[0]) |-> !ACCUM_IN_IRQ)
    else $error("input request while disabled");
  chk_port7_mask: assert property (
    !msk_sh[7] && !$past(msk_sh[7]) |-> $stable(TIMER_PORT[7]))
    else $error("port bit 7 moved with mask clear");
  chk_port7_conn: assert property (
    (!ios_sh[7] || dis_sh[7]) && (!$past(ios_sh[7]) || $past(dis_sh[7]))
    |-> $stable(TIMER_PORT[7]))
    else $error("port bit 7 moved while not connected");
endmodule // tpa_top_props

bind tpa_top tpa_top_props tpa_top_props_i (
  .SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
  .PRDATA(PRDATA), .PSLVERR(PSLVERR), .CH7_PIN(CH7_PIN),
  .LOW_CMP_EVT(LOW_CMP_EVT), .LOW_CMP_LVL(LOW_CMP_LVL),
  .TIMER_PORT(TIMER_PORT), .ACCUM_OVF_IRQ(ACCUM_OVF_IRQ),
  .ACCUM_IN_IRQ(ACCUM_IN_IRQ)
);

// file: testbench/tpa_top_test.sv
`timescale 1ns/10ps
`include "tpa_consts.svh"
module tpa_top_test;
  logic        clk, rst, psel, pen, pwr, ready, err, lerr;
  logic        pin, start, idle, busy, ovf_irq, in_irq;
  logic [1:0]  hi;
  logic [6:0]  levt, llvl;
  logic [7:0]  port, p, msk, ios, dis;
  logic [9:0]  width;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, a, seed;
  int          n_errors, cmp_count, k;
  logic [7:0]  ctl_t [5] = '{8'h88, 8'h80, 8'h83, 8'h88, 8'h08};
  logic [7:0]  sel_t [5] = '{8'h04, 8'h00, 8'h00, 8'hFF, 8'hFF};

  tpa_top tpa_top_i (
    .SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PREADY(ready), .PRDATA(prdata),
    .PSLVERR(err), .CH7_PIN(pin), .LOW_CMP_EVT(levt), .LOW_CMP_LVL(llvl),
    .TIMER_PORT(port), .ACCUM_OVF_IRQ(ovf_irq), .ACCUM_IN_IRQ(in_irq)
  );
  tpa_pulse_src tpa_pulse_src_i (.clk(clk), .start(start), .idle(idle),
    .width(width), .pin(pin), .busy(busy));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Ticks over the 2563-cycle window between the two count samples
  function automatic logic [31:0] exp_ticks(input logic [7:0] c,
                                            input logic [7:0] s);
    int n;
    n = c[3] ? s + 1 : 1 << c[2:0];
    return c[7] ? 2563 / n : 0;
  endfunction
  function automatic logic [7:0] port_next(input logic [7:0] q,
    input logic [7:0] g, input logic [7:0] v);
    return (q & ~g) | (v & g);
  endfunction

  task automatic complete_run;
    if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic hang;
    n_errors++;
    complete_run();
  endtask
  // Tolerance covers the prescaler and divider phase at start
  task automatic check(input logic [31:0] g, input logic [31:0] x,
                       input int t);
    cmp_count++;
    if ((g + t >= x && g <= x + t) !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, x);
    end
  endtask
  // One APB transfer; idle cycle first so no signal is driven twice
  task automatic apb(input logic w, input logic [7:0] i,
                     input logic [31:0] v);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {hi, i, 2'b00};
    pwdata <= v;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ready !== 1'b1 && k < 20);
    rd = prdata;
    lerr = err;
    psel <= 1'b0;
    pen <= 1'b0;
    if (ready !== 1'b1) hang();
  endtask
  task automatic pulse(input logic [9:0] w, input bit mid, input int e);
    width <= w;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    if (mid) begin
      repeat (12) @(posedge clk);
      apb(0, `TPA_IDX_ACC_COUNT, 0);
      check(rd, e, 0);
    end
    repeat (2) @(posedge clk);
    for (k = 0; busy !== 1'b0 && k < 2000; k++) @(posedge clk);
    if (busy !== 1'b0) hang();
    repeat (8) @(posedge clk);
  endtask
  task automatic irq_t(input logic [7:0] i, input logic [7:0] c,
                       input logic [31:0] x);
    apb(1, i, c);
    repeat (2) @(posedge clk);
    check(32'({ovf_irq, in_irq}), x, 0);
  endtask

  initial begin
    rst = 1'b1;
    {psel, pen, pwr, start, idle, hi} = '0;
    {paddr, pwdata, levt, llvl, width} = '0;
    seed = 32'h05a5_0508;
    n_errors = 0;
    cmp_count = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // Reset values, then refused accesses
    for (int j = 3; j <= 42; j++) if (j < 5 || j > 31) begin
      apb(0, j[7:0], 0);
      check(rd, 0, 0);
    end
    hi <= 2'b01;
    apb(0, `TPA_IDX_CMP_DATA, 0);
    check(32'(lerr), 1, 0);
    hi <= 2'b00;
    apb(0, 8'h30, 0);
    check(32'(lerr), 1, 0);
    repeat (6) begin
      seed = xs(seed);
      apb(1, `TPA_IDX_CMP_DATA, seed);
      apb(0, `TPA_IDX_CMP_DATA, 0);
      check(rd, {24'h00_0000, seed[7:0]}, 0);
    end
    // Prescale factors, boundaries and timer disable
    for (int t = 0; t < 5; t++) begin
      apb(1, `TPA_IDX_PRESCALE, sel_t[t]);
      apb(1, `TPA_IDX_SYS_CTL, ctl_t[t]);
      // Let the old factor run out before the window opens
      repeat (300) @(posedge clk);
      apb(0, `TPA_IDX_COUNT, 0);
      a = rd;
      repeat (2560) @(posedge clk);
      apb(0, `TPA_IDX_COUNT, 0);
      check((rd - a) & 32'h0000_FFFF, exp_ticks(ctl_t[t], sel_t[t]), 2);
    end
    // Accumulator modes and edges with the main timer off
    for (int m = 0; m < 2; m++) for (int e = 0; e < 2; e++) begin
      idle <= m && e;
      apb(1, `TPA_IDX_ACC_CTL, 0);
      apb(1, `TPA_IDX_ACC_COUNT, 0);
      apb(1, `TPA_IDX_ACC_FLAGS, 3);
      apb(1, `TPA_IDX_ACC_CTL, 64 + 32 * m + 16 * e);
      pulse(m ? 640 : 40, m == 0, e);
      apb(0, `TPA_IDX_ACC_COUNT, 0);
      check(rd, m ? 10 : 1, m);
      apb(0, `TPA_IDX_ACC_FLAGS, 0);
      check(rd & 1, 1, 0);
    end
    apb(1, `TPA_IDX_ACC_COUNT, 32'h0000_FFFF);
    apb(1, `TPA_IDX_ACC_FLAGS, 3);
    apb(1, `TPA_IDX_ACC_CTL, 8'h43);
    pulse(40, 0, 0);
    apb(0, `TPA_IDX_ACC_FLAGS, 0);
    check(rd, 3, 0);
    irq_t(`TPA_IDX_ACC_CTL, 8'h40, 0);
    irq_t(`TPA_IDX_ACC_CTL, 8'h43, 3);
    irq_t(`TPA_IDX_ACC_FLAGS, 8'h03, 0);
    // Channel 7 events over low-channel compares
    seed = xs(seed);
    msk = seed[7:0];
    apb(1, `TPA_IDX_IO_SEL, 8'hFF);
    apb(1, `TPA_IDX_CMP_MASK, msk);
    apb(1, `TPA_IDX_TOGGLE, 8'h80);
    apb(1, `TPA_IDX_SYS_CTL, 0); // Divide by one once the timer starts
    levt <= 7'h7F;
    llvl <= seed[14:8];
    @(posedge clk);
    levt <= 7'h00;
    repeat (2) @(posedge clk);
    // No channel 7 event: every connected low bit follows its compare
    p = port_next(8'h00, 8'h7F, {1'b0, seed[14:8]});
    check(port, p, 0);
    for (int r = 0; r < 2; r++) begin
      seed = xs(seed);
      ios = r ? seed[7:0] : 8'hFF;
      dis = r ? seed[15:8] : 8'h00;
      apb(1, `TPA_IDX_IO_SEL, ios);
      apb(1, `TPA_IDX_PIN_DISC, dis);
      apb(1, `TPA_IDX_CMP_DATA, seed[23:16]);
      apb(1, `TPA_IDX_COUNT, 32'h0000_FFF0);
      levt <= 7'h7F;
      apb(1, `TPA_IDX_SYS_CTL, 8'h80);
      // Events at FFFF and 0000 land 16 and 17 edges on; low compares
      // stop right after, so the override is what the port keeps
      repeat (17) @(posedge clk);
      levt <= 7'h00;
      repeat (283) @(posedge clk);
      apb(1, `TPA_IDX_SYS_CTL, 0);
      p = port_next(p, {1'b0, ios[6:0] & ~dis[6:0]}, {1'b0, llvl});
      p = port_next(p, msk & ios & ~dis, seed[23:16]);
      check(port, p, 0);
    end
    complete_run();
  end
endmodule // tpa_top_test
